// ===== hw/fpe_pkg.sv
// Constants and types shared by the flash program and erase sequencer.
package fpe_pkg;

	localparam int unsigned CLK_PERIOD_NS = 5;

	// Wait and pulse times in their own units.
	localparam int unsigned T_SSWE_US = 1;
	localparam int unsigned T_SPSU_US = 50;
	localparam int unsigned T_SP30_US = 30;
	localparam int unsigned T_SP200_US = 200;
	localparam int unsigned T_SP10_US = 10;
	localparam int unsigned T_CP_US = 5;
	localparam int unsigned T_CPSU_US = 5;
	localparam int unsigned T_SPV_US = 4;
	localparam int unsigned T_SPVR_US = 2;
	localparam int unsigned T_CPV_US = 2;
	localparam int unsigned T_CSWE_US = 100;
	localparam int unsigned T_SESU_US = 100;
	localparam int unsigned T_SE_SHORT_MS = 10;
	localparam int unsigned T_SE_LONG_MS = 100;
	localparam int unsigned T_CE_US = 10;
	localparam int unsigned T_CESU_US = 10;
	localparam int unsigned T_SEV_US = 20;
	localparam int unsigned T_SEVR_US = 2;
	localparam int unsigned T_CEV_US = 4;
	localparam int unsigned T_PROG_LIMIT_MS = 200;
	localparam int unsigned T_ERASE_LIMIT_MS = 1200;

	// Cycle counts, least times rounded up.
	localparam int unsigned CYC_SSWE =
		(T_SSWE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CYC_SPSU =
		(T_SPSU_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CYC_SP30 = T_SP30_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned CYC_SP200 = T_SP200_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned CYC_SP10 = T_SP10_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned CYC_CP =
		(T_CP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CYC_CPSU =
		(T_CPSU_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CYC_SPV =
		(T_SPV_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CYC_SPVR =
		(T_SPVR_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CYC_CPV =
		(T_CPV_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CYC_CSWE =
		(T_CSWE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CYC_SESU =
		(T_SESU_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CYC_SE_SHORT =
		T_SE_SHORT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned CYC_SE_LONG = T_SE_LONG_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned CYC_CE =
		(T_CE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CYC_CESU =
		(T_CESU_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CYC_SEV =
		(T_SEV_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CYC_SEVR =
		(T_SEVR_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CYC_CEV =
		(T_CEV_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CYC_PROG_LIMIT =
		T_PROG_LIMIT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned CYC_ERASE_LIMIT =
		T_ERASE_LIMIT_MS * 1000000 / CLK_PERIOD_NS;

	// Counts and widths.
	localparam int unsigned UNIT_BYTES = 128;
	localparam int unsigned BUF_AW = 7;
	localparam int unsigned FL_AW = 24;
	localparam logic [9:0] PROG_MAX_COUNT = 10'h3e8;
	localparam logic [9:0] PROG_SHORT_LAST = 10'h006;
	localparam logic [9:0] ERASE_COUNT_SHORT = 10'h078;
	localparam logic [9:0] ERASE_COUNT_LONG = 10'h00c;
	localparam logic [7:0] VERIFY_DUMMY = 8'hff;
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	typedef enum logic [3:0] {
		ST_IDLE, ST_SWE, ST_LOAD, ST_SETUP, ST_PULSE, ST_PCLR, ST_SCLR,
		ST_VSET, ST_DUMMY, ST_READ, ST_CMP, ST_VCLR, ST_DECIDE, ST_SWE_CLR
	} fpe_state_type;

endpackage

// ===== hw/fpe_timer.sv
// Down counter that reports the end of a loaded wait.
`timescale 1ns/1ps
module fpe_timer
	import fpe_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic start,
	input wire logic [31:0] count,
	output logic done
);

	logic [31:0] remain;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			remain <= 32'h0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				remain <= count;
			end else if (remain != 32'h0) begin
				remain <= remain - 32'h1;
				done <= (remain == 32'h1);
			end
		end
	end

endmodule

// ===== hw/fpe_mem.sv
// Byte memory for one programming unit with registered read data.
`timescale 1ns/1ps
module fpe_mem
	import fpe_pkg::*;
(
	input wire logic clk_sys,
	input wire logic we,
	input wire logic [BUF_AW-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [BUF_AW-1:0] raddr,
	output logic [7:0] rdata
);

	logic [7:0] store [UNIT_BYTES];

	always_ff @(posedge clk_sys) begin
		if (we) begin
			store[waddr] <= wdata;
		end
		rdata <= store[raddr];
	end

endmodule

// ===== hw/fpe_sequencer.sv
// Controller that steps the flash control bits for programming and erasing.
`timescale 1ns/1ps
// What this block does
// - Wait 1 us after write enable set.
// - Wait 50 us after program setup set.
// - Pulse 30 us for iterations one to six.
// - Pulse 200 us for iterations seven onward.
// - Additional programming pulse lasts 10 us.
// - Wait 5 us after program pulse clear.
// - Wait 5 us after program setup clear.
// - Wait 4 us after program verify set.
// - Dummy write FF, wait 2 us, read.
// - Wait 2 us after program verify clear.
// - Wait 100 us after write enable clear.
// - Fail after 1000 programming iterations.
// - Total program pulse per unit within 200 ms.
// - Wait 100 us after erase setup set.
// - Erase pulse between 10 and 100 ms.
// - Wait 10 us after erase pulse clear.
// - Wait 10 us after erase setup clear.
// - Wait 20 us after erase verify set.
// - Wait 4 us after erase verify clear.
// - Pulse time times count gives erase limit.
// - Total erase pulse per block within 1200 ms.
module fpe_sequencer
	import fpe_pkg::*;
#(
	parameter int unsigned P_CYC_SPSU = CYC_SPSU,
	parameter int unsigned P_CYC_SP30 = CYC_SP30,
	parameter int unsigned P_CYC_SP200 = CYC_SP200,
	parameter int unsigned P_CYC_CSWE = CYC_CSWE,
	parameter int unsigned P_CYC_SESU = CYC_SESU,
	parameter int unsigned P_CYC_SE_SHORT = CYC_SE_SHORT,
	parameter int unsigned P_CYC_SE_LONG = CYC_SE_LONG,
	parameter int unsigned P_CYC_PROG_LIMIT = CYC_PROG_LIMIT,
	parameter int unsigned P_CYC_ERASE_LIMIT = CYC_ERASE_LIMIT
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic start_program,
	input wire logic start_erase,
	input wire logic erase_long_pulse,
	input wire logic [FL_AW-1:0] program_base,
	input wire logic [FL_AW-1:0] erase_base,
	input wire logic [FL_AW-1:0] erase_bytes,
	input wire logic buf_wr,
	input wire logic [BUF_AW-1:0] buf_addr,
	input wire logic [7:0] buf_wdata,
	output logic busy,
	output logic done,
	output logic failed,
	output logic [9:0] iterations,
	output logic software_write_enable,
	output logic program_setup,
	output logic program_pulse,
	output logic program_verify,
	output logic erase_setup,
	output logic erase_pulse,
	output logic erase_verify,
	output logic flash_wr,
	output logic flash_rd,
	output logic [FL_AW-1:0] flash_addr,
	output logic [7:0] flash_wdata,
	input wire logic [7:0] flash_rdata
);

	fpe_state_type state;
	logic is_erase;
	logic long_pulse;
	logic addl;
	logic all_ok;
	logic phase;
	logic [FL_AW-1:0] idx;
	logic [31:0] pulse_total;
	logic tmr_start;
	logic [31:0] tmr_count;
	logic tmr_done;
	logic rp_we;
	logic [BUF_AW-1:0] rp_waddr;
	logic [7:0] rp_wdata;
	logic [7:0] orig_data;
	logic [7:0] reprog_data;
	logic [31:0] pulse_cyc;
	logic [31:0] limit_cyc;
	logic [9:0] max_count;
	logic over_limit;
	logic last_byte;
	logic [7:0] expect_byte;

	////////////////////////////////////////////////////////////////////////////
	// Data memories and wait timer.

	fpe_mem u_orig (
		.clk_sys(clk_sys),
		.we(buf_wr & ~busy),
		.waddr(buf_addr),
		.wdata(buf_wdata),
		.raddr(idx[BUF_AW-1:0]),
		.rdata(orig_data)
	);

	fpe_mem u_reprog (
		.clk_sys(clk_sys),
		.we(rp_we | (buf_wr & ~busy)),
		.waddr(rp_we ? rp_waddr : buf_addr),
		.wdata(rp_we ? rp_wdata : buf_wdata),
		.raddr(idx[BUF_AW-1:0]),
		.rdata(reprog_data)
	);

	fpe_timer u_timer (
		.clk_sys(clk_sys),
		.rst(rst),
		.start(tmr_start),
		.count(tmr_count),
		.done(tmr_done)
	);

	////////////////////////////////////////////////////////////////////////////
	// Pulse length, limits and verify expectation.

	always_comb begin
		if (is_erase) begin
			pulse_cyc = 32'(long_pulse ? P_CYC_SE_LONG : P_CYC_SE_SHORT);
			max_count = long_pulse ? ERASE_COUNT_LONG : ERASE_COUNT_SHORT;
			limit_cyc = 32'(P_CYC_ERASE_LIMIT);
			expect_byte = ERASED_BYTE;
			last_byte = (idx + 24'h1 >= erase_bytes);
		end else begin
			if (addl) begin
				pulse_cyc = 32'(CYC_SP10);
			end else if (iterations <= PROG_SHORT_LAST) begin
				pulse_cyc = 32'(P_CYC_SP30);
			end else begin
				pulse_cyc = 32'(P_CYC_SP200);
			end
			max_count = PROG_MAX_COUNT;
			limit_cyc = 32'(P_CYC_PROG_LIMIT);
			expect_byte = orig_data;
			last_byte = (idx[BUF_AW-1:0] == 7'h7f);
		end
		over_limit = (pulse_total + pulse_cyc > limit_cyc);
	end

	////////////////////////////////////////////////////////////////////////////
	// Accumulated pulse time of the current unit or block.

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pulse_total <= 32'h0;
		end else if (state == ST_IDLE) begin
			pulse_total <= 32'h0;
		end else if (program_pulse | erase_pulse) begin
			pulse_total <= pulse_total + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequence of control bits and waits.

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			is_erase <= 1'b0;
			long_pulse <= 1'b0;
			addl <= 1'b0;
			all_ok <= 1'b0;
			phase <= 1'b0;
			idx <= 24'h0;
			iterations <= 10'h0;
			busy <= 1'b0;
			done <= 1'b0;
			failed <= 1'b0;
			tmr_start <= 1'b0;
			tmr_count <= 32'h0;
			software_write_enable <= 1'b0;
			program_setup <= 1'b0;
			program_pulse <= 1'b0;
			program_verify <= 1'b0;
			erase_setup <= 1'b0;
			erase_pulse <= 1'b0;
			erase_verify <= 1'b0;
			flash_wr <= 1'b0;
			flash_rd <= 1'b0;
			flash_addr <= 24'h0;
			flash_wdata <= 8'h0;
			rp_we <= 1'b0;
			rp_waddr <= 7'h0;
			rp_wdata <= 8'h0;
		end else begin
			tmr_start <= 1'b0;
			flash_wr <= 1'b0;
			flash_rd <= 1'b0;
			done <= 1'b0;
			rp_we <= 1'b0;
			unique case (state)
			ST_IDLE: begin
				if (start_program | start_erase) begin
					is_erase <= ~start_program;
					long_pulse <= erase_long_pulse;
					busy <= 1'b1;
					failed <= 1'b0;
					addl <= 1'b0;
					phase <= 1'b0;
					idx <= 24'h0;
					iterations <= 10'h1;
					software_write_enable <= 1'b1;
					tmr_start <= 1'b1;
					tmr_count <= 32'(CYC_SSWE);
					state <= ST_SWE;
				end
			end
			ST_SWE: begin
				if (tmr_done) begin
					if (is_erase) begin
						erase_setup <= 1'b1;
						tmr_start <= 1'b1;
						tmr_count <= 32'(P_CYC_SESU);
						state <= ST_SETUP;
					end else begin
						state <= ST_LOAD;
					end
				end
			end
			ST_LOAD: begin
				phase <= ~phase;
				if (phase) begin
					flash_wr <= 1'b1;
					flash_addr <= program_base + idx;
					flash_wdata <= addl ? orig_data : reprog_data;
					if (last_byte) begin
						idx <= 24'h0;
						program_setup <= 1'b1;
						tmr_start <= 1'b1;
						tmr_count <= 32'(P_CYC_SPSU);
						state <= ST_SETUP;
					end else begin
						idx <= idx + 24'h1;
					end
				end
			end
			ST_SETUP: begin
				if (tmr_done) begin
					tmr_start <= 1'b1;
					if (over_limit) begin
						failed <= 1'b1;
						program_setup <= 1'b0;
						erase_setup <= 1'b0;
						tmr_count <= 32'(is_erase ? CYC_CESU : CYC_CPSU);
						state <= ST_SCLR;
					end else begin
						program_pulse <= ~is_erase;
						erase_pulse <= is_erase;
						tmr_count <= pulse_cyc;
						state <= ST_PULSE;
					end
				end
			end
			ST_PULSE: begin
				if (tmr_done) begin
					program_pulse <= 1'b0;
					erase_pulse <= 1'b0;
					tmr_start <= 1'b1;
					tmr_count <= 32'(is_erase ? CYC_CE : CYC_CP);
					state <= ST_PCLR;
				end
			end
			ST_PCLR: begin
				if (tmr_done) begin
					program_setup <= 1'b0;
					erase_setup <= 1'b0;
					tmr_start <= 1'b1;
					tmr_count <= 32'(is_erase ? CYC_CESU : CYC_CPSU);
					state <= ST_SCLR;
				end
			end
			ST_SCLR: begin
				if (tmr_done) begin
					if (failed) begin
						software_write_enable <= 1'b0;
						tmr_start <= 1'b1;
						tmr_count <= 32'(P_CYC_CSWE);
						state <= ST_SWE_CLR;
					end else if (addl) begin
						state <= ST_DECIDE;
					end else begin
						program_verify <= ~is_erase;
						erase_verify <= is_erase;
						all_ok <= 1'b1;
						idx <= 24'h0;
						tmr_start <= 1'b1;
						tmr_count <= 32'(is_erase ? CYC_SEV : CYC_SPV);
						state <= ST_VSET;
					end
				end
			end
			ST_VSET, ST_CMP: begin
				if ((state == ST_VSET) ? tmr_done : 1'b1) begin
					if (state == ST_CMP) begin
						all_ok <= all_ok & (flash_rdata == expect_byte);
						rp_we <= ~is_erase;
						rp_waddr <= idx[BUF_AW-1:0];
						rp_wdata <= expect_byte | ~flash_rdata;
					end
					if (state == ST_CMP && last_byte) begin
						program_verify <= 1'b0;
						erase_verify <= 1'b0;
						tmr_start <= 1'b1;
						tmr_count <= 32'(is_erase ? CYC_CEV : CYC_CPV);
						state <= ST_VCLR;
					end else begin
						if (state == ST_CMP) begin
							idx <= idx + 24'h1;
						end
						flash_wr <= 1'b1;
						flash_addr <= (is_erase ? erase_base : program_base) +
							((state == ST_CMP) ? idx + 24'h1 : idx);
						flash_wdata <= VERIFY_DUMMY;
						tmr_start <= 1'b1;
						tmr_count <= 32'(is_erase ? CYC_SEVR : CYC_SPVR);
						state <= ST_DUMMY;
					end
				end
			end
			ST_DUMMY: begin
				if (tmr_done) begin
					flash_rd <= 1'b1;
					state <= ST_READ;
				end
			end
			ST_READ: begin
				state <= ST_CMP;
			end
			ST_VCLR: begin
				if (tmr_done) begin
					state <= ST_DECIDE;
				end
			end
			ST_DECIDE: begin
				if (!is_erase && !addl && iterations <= PROG_SHORT_LAST) begin
					addl <= 1'b1;
					idx <= 24'h0;
					phase <= 1'b0;
					state <= ST_LOAD;
				end else if (all_ok || iterations >= max_count) begin
					failed <= ~all_ok;
					software_write_enable <= 1'b0;
					tmr_start <= 1'b1;
					tmr_count <= 32'(P_CYC_CSWE);
					state <= ST_SWE_CLR;
				end else begin
					iterations <= iterations + 10'h1;
					addl <= 1'b0;
					idx <= 24'h0;
					phase <= 1'b0;
					if (is_erase) begin
						erase_setup <= 1'b1;
						tmr_start <= 1'b1;
						tmr_count <= 32'(P_CYC_SESU);
						state <= ST_SETUP;
					end else begin
						state <= ST_LOAD;
					end
				end
			end
			ST_SWE_CLR: begin
				if (tmr_done) begin
					busy <= 1'b0;
					done <= 1'b1;
					state <= ST_IDLE;
				end
			end
			endcase
		end
	end

endmodule

// ===== sim/fpe_sequencer_asserts.sv
// Timing checks on the flash control outputs of the sequencer.
`timescale 1ns/1ps
module fpe_sequencer_asserts
	import fpe_pkg::*;
#(
	parameter int unsigned P_CYC_SPSU = CYC_SPSU,
	parameter int unsigned P_CYC_SP30 = CYC_SP30,
	parameter int unsigned P_CYC_SP200 = CYC_SP200,
	parameter int unsigned P_CYC_CSWE = CYC_CSWE,
	parameter int unsigned P_CYC_SESU = CYC_SESU,
	parameter int unsigned P_CYC_SE_SHORT = CYC_SE_SHORT,
	parameter int unsigned P_CYC_SE_LONG = CYC_SE_LONG
) (
	input logic clk_sys,
	input logic rst,
	input logic done,
	input logic [9:0] iterations,
	input logic software_write_enable,
	input logic program_setup,
	input logic program_pulse,
	input logic program_verify,
	input logic erase_setup,
	input logic erase_pulse,
	input logic erase_verify,
	input logic flash_wr,
	input logic flash_rd,
	input logic [7:0] flash_wdata
);
	logic [6:0] ctl;
	logic [6:0] last;
	int unsigned cnt;
	int unsigned wgap;
	int unsigned pvgap;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	assign ctl = {software_write_enable, program_setup, program_pulse,
		program_verify, erase_setup, erase_pulse, erase_verify};
	// Cycles since the last change of any control bit.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			last <= 7'h0;
			cnt <= 32'h0;
		end else if (ctl != last) begin
			last <= ctl;
			cnt <= 32'h1;
		end else begin
			cnt <= cnt + 32'h1;
		end
	end
	// Cycles since the last flash write strobe.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			wgap <= 32'h0;
		else if (flash_wr)
			wgap <= 32'h1;
		else
			wgap <= wgap + 32'h1;
	end
	// Cycles since program verify was last seen high.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			pvgap <= 32'h00100000;
		else if (program_verify)
			pvgap <= 32'h1;
		else
			pvgap <= pvgap + 32'h1;
	end
	////////////////////////////////////////
	a_setup_after_we: assert property (
		$rose(program_setup) || $rose(erase_setup) |->
		software_write_enable && cnt >= CYC_SSWE) else $error("early setup");
	a_pulse_after_su: assert property (
		$rose(program_pulse) |-> cnt == P_CYC_SPSU + 2) else $error("pulse");
	a_short_pulse: assert property (
		$fell(program_pulse) && iterations <= 10'h6 |->
		cnt == P_CYC_SP30 + 2 || cnt == CYC_SP10 + 2) else $error("short");
	a_long_pulse: assert property (
		$fell(program_pulse) && iterations > 10'h6 |->
		cnt == P_CYC_SP200 + 2) else $error("long pulse");
	a_su_clear_wait: assert property (
		$fell(program_setup) |-> cnt == CYC_CP + 2) else $error("su clear");
	a_pv_set_wait: assert property (
		$rose(program_verify) |-> cnt == CYC_CPSU + 2) else $error("pv set");
	a_dummy_wait: assert property (
		flash_wr && (program_verify || erase_verify) |->
		cnt >= (program_verify ? CYC_SPV : CYC_SEV)) else $error("dummy");
	a_dummy_value: assert property (
		flash_wr && (program_verify || erase_verify) |->
		flash_wdata == VERIFY_DUMMY) else $error("dummy value");
	a_read_gap: assert property (
		flash_rd |-> wgap == (program_verify ? CYC_SPVR : CYC_SEVR) + 2)
		else $error("read gap");
	a_after_pv_clear: assert property (
		(ctl != last || flash_wr) && !program_verify &&
		!$past(program_verify) |-> pvgap >= CYC_CPV)
		else $error("pv clear");
	a_done_after_we: assert property (
		done |-> !software_write_enable && cnt >= P_CYC_CSWE)
		else $error("done early");
	a_erase_after_su: assert property (
		$rose(erase_pulse) |-> cnt == P_CYC_SESU + 2) else $error("erase");
	a_erase_width: assert property (
		$fell(erase_pulse) |-> cnt == P_CYC_SE_SHORT + 2 ||
		cnt == P_CYC_SE_LONG + 2) else $error("erase width");
	a_esu_clear_wait: assert property (
		$fell(erase_setup) |-> cnt == CYC_CE + 2) else $error("esu clear");
	a_ev_set_wait: assert property (
		$rose(erase_verify) |-> cnt == CYC_CESU + 2) else $error("ev set");
endmodule

bind fpe_sequencer fpe_sequencer_asserts #(.P_CYC_SPSU(P_CYC_SPSU),
	.P_CYC_SP30(P_CYC_SP30), .P_CYC_SP200(P_CYC_SP200),
	.P_CYC_CSWE(P_CYC_CSWE), .P_CYC_SESU(P_CYC_SESU),
	.P_CYC_SE_SHORT(P_CYC_SE_SHORT), .P_CYC_SE_LONG(P_CYC_SE_LONG)
) chk (.clk_sys, .rst, .done, .iterations, .software_write_enable,
	.program_setup, .program_pulse, .program_verify, .erase_setup,
	.erase_pulse, .erase_verify, .flash_wr, .flash_rd, .flash_wdata);

// ===== sim/fpe_flash_model.sv
// Behavioural flash array that answers the sequencer's strobes.
`timescale 1ns/1ps
module fpe_flash_model #(
	parameter int unsigned ERASE_PULSES = 2
) (
	input logic clk_sys,
	input logic software_write_enable,
	input logic program_pulse,
	input logic program_verify,
	input logic erase_pulse,
	input logic erase_verify,
	input logic flash_wr,
	input logic flash_rd,
	input logic [23:0] flash_addr,
	input logic [7:0] flash_wdata,
	output logic [7:0] flash_rdata
);
	logic [7:0] mem [256];
	logic [7:0] lat [256];
	logic pp_q = 1'b0;
	logic ep_q = 1'b0;
	logic armed = 1'b0;
	int unsigned n_erase = 0;
	initial begin
		flash_rdata = 8'h0;
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'hff;
			lat[i] = 8'hff;
		end
	end
	always @(posedge clk_sys) begin
		pp_q <= program_pulse;
		ep_q <= erase_pulse;
		if (flash_wr && software_write_enable && !program_verify &&
			!erase_verify)
			lat[flash_addr[7:0]] <= flash_wdata;
		if (flash_wr && (program_verify || erase_verify))
			armed <= flash_wdata == 8'hff;
		if (program_pulse && !pp_q) begin
			for (int i = 0; i < 256; i++) begin
				mem[i] <= mem[i] & lat[i];
				lat[i] <= 8'hff;
			end
		end
		if (erase_pulse && !ep_q) begin
			n_erase <= n_erase + 1;
			if (n_erase + 1 >= ERASE_PULSES)
				for (int i = 0; i < 256; i++)
					mem[i] <= 8'hff;
		end
		if (flash_rd) begin
			armed <= 1'b0;
			flash_rdata <= armed ? mem[flash_addr[7:0]] : 8'h0f;
		end else begin
			flash_rdata <= ~flash_rdata;
		end
	end
endmodule

// ===== sim/fpe_sequencer_bench.sv
// Self-checking bench for the flash program and erase sequencer.
`timescale 1ns/1ps
module fpe_sequencer_bench import fpe_pkg::*; ();
	logic clk_sys, rst, start_program, start_erase, erase_long_pulse;
	logic [FL_AW-1:0] program_base, erase_base, erase_bytes;
	logic buf_wr, busy, done, failed, flash_wr, flash_rd;
	logic [BUF_AW-1:0] buf_addr;
	logic [7:0] buf_wdata, flash_wdata, flash_rdata;
	logic [9:0] iterations;
	logic [FL_AW-1:0] flash_addr;
	logic software_write_enable, program_setup, program_pulse;
	logic program_verify, erase_setup, erase_pulse, erase_verify;
	int n_errors = 0;
	int n_tests = 0;
	int n_pp, n_ep, n_rd, n_dw;
	fpe_sequencer #(.P_CYC_SPSU(50), .P_CYC_SP30(30), .P_CYC_CSWE(40),
		.P_CYC_SESU(40), .P_CYC_SE_SHORT(100)
	) uut (.clk_sys, .rst, .start_program, .start_erase, .erase_long_pulse,
		.program_base, .erase_base, .erase_bytes, .buf_wr, .buf_addr,
		.buf_wdata, .busy, .done, .failed, .iterations,
		.software_write_enable, .program_setup, .program_pulse,
		.program_verify, .erase_setup, .erase_pulse, .erase_verify,
		.flash_wr, .flash_rd, .flash_addr, .flash_wdata, .flash_rdata);
	fpe_flash_model fm (.clk_sys, .software_write_enable, .program_pulse,
		.program_verify, .erase_pulse, .erase_verify, .flash_wr,
		.flash_rd, .flash_addr, .flash_wdata, .flash_rdata);
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge program_pulse) n_pp++;
	always @(posedge erase_pulse) n_ep++;
	always @(posedge clk_sys) begin
		if (flash_rd)
			n_rd++;
		if (flash_wr && (program_verify || erase_verify))
			n_dw++;
	end
	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task tick;
		@(posedge clk_sys);
		#1;
	endtask
	task wait_done;
		n_pp = 0;
		n_ep = 0;
		n_rd = 0;
		n_dw = 0;
		for (int i = 0; i < 100000 && done !== 1'b1; i++)
			tick;
		chk(done, 1'b1);
	endtask
	task report_and_stop;
		if (n_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////
	task t_program;
		for (int k = 0; k < 128; k++) begin
			buf_wr = 1'b1;
			buf_addr = k[6:0];
			buf_wdata = k[7:0] ^ 8'h5a;
			tick;
		end
		buf_wr = 1'b0;
		start_program = 1'b1;
		start_erase = 1'b1;
		tick;
		chk(busy, 1'b1);
		// Buffer write while busy must be ignored.
		buf_wr = 1'b1;
		buf_addr = 7'h0;
		buf_wdata = 8'h0;
		tick;
		start_program = 1'b0;
		start_erase = 1'b0;
		buf_wr = 1'b0;
		wait_done;
		chk({failed, iterations}, 11'h001);
		chk(n_pp, 2);
		chk(n_ep, 0);
		chk(n_dw, 128);
		for (int k = 0; k < 128; k++)
			chk(fm.mem[k], k[7:0] ^ 8'h5a);
	endtask
	task t_erase;
		start_erase = 1'b1;
		tick;
		start_erase = 1'b0;
		wait_done;
		chk({failed, iterations}, 11'h002);
		chk(n_ep, 2);
		chk(n_rd, 4);
		chk({fm.mem[0], fm.mem[1]}, {ERASED_BYTE, ERASED_BYTE});
	endtask
	task t_abort;
		erase_long_pulse = 1'b1;
		start_erase = 1'b1;
		tick;
		start_erase = 1'b0;
		repeat (300) tick;
		chk(erase_pulse, 1'b1);
		rst = 1'b1;
		#1;
		chk({busy, software_write_enable, erase_setup, erase_pulse}, 0);
		tick;
		rst = 1'b0;
		tick;
		chk({busy, done, failed, erase_verify}, 0);
	endtask
	initial begin
		rst = 1'b1;
		start_program = 1'b0;
		start_erase = 1'b0;
		erase_long_pulse = 1'b0;
		buf_wr = 1'b0;
		buf_addr = 7'h0;
		buf_wdata = 8'h0;
		program_base = 24'h000100;
		erase_base = 24'h000100;
		erase_bytes = 24'h000002;
		repeat (12) @(posedge clk_sys);
		#1 rst = 1'b0;
		tick;
		chk({busy, done, failed, iterations, software_write_enable,
			program_setup, erase_setup, flash_wr, flash_rd}, 0);
		t_program;
		t_erase;
		t_abort;
		report_and_stop;
	end
	initial begin
		#480000;
		n_errors++;
		report_and_stop;
	end
endmodule
